// ===== logic/ddr_burst2_sram_defines.svh
// Constants of the double-data-rate burst-of-two SRAM port
`ifndef DDR_BURST2_SRAM_DEFINES_SVH
`define DDR_BURST2_SRAM_DEFINES_SVH

// Word width of the wide configuration, address width of the word-pair array
`define DATA_W          36
`define ADDR_W          8

// Recent-write history that keeps reads coherent with uncommitted writes
`define SHADOW_N        4

// Entries of the write buffer between the link and the array
`define WBUF_DEPTH      2

// Reset values
`define PHASE_RST       1'b0
`define MODE_RST        1'b1

`endif

// ===== logic/ddr_burst2_sram_pkg.sv
// Types shared by the SRAM port, the link controller model and the testbench
`include "ddr_burst2_sram_defines.svh"

package ddr_burst2_sram_pkg;

    typedef logic [`DATA_W-1:0] word_t;
    typedef logic [`ADDR_W-1:0] addr_t;

    // Two words of one burst
    typedef struct packed {
        word_t word0;
        word_t word1;
    } rdPair_t;

    // One complete write burst
    typedef struct packed {
        addr_t addr;
        word_t word0;
        word_t word1;
    } wrReq_t;

    // Self-timed array write sequencer
    typedef enum logic [2:0] {
        CM_IDLE  = 3'b001,
        CM_WORD0 = 3'b010,
        CM_WORD1 = 3'b100
    } commitState_t;

endpackage

// ===== logic/async_pair_fifo.sv
// Dual-clock FIFO with gray-coded pointers, valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none

module async_pair_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Filling side
    input  wire logic             wrClk,
    input  wire logic             wrRstn,
    input  wire logic             wrValid,
    output logic                  wrReady,
    input  wire logic [WIDTH-1:0] wrData,
    // Draining side
    input  wire logic             rdClk,
    input  wire logic             rdRstn,
    output logic                  rdValid,
    input  wire logic             rdReady,
    output logic [WIDTH-1:0]      rdData
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int PW = AW + 1;

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW-1:0]    wrBin_reg;
    logic [PW-1:0]    wrBin_next;
    logic [PW-1:0]    wrGray_reg;
    logic [PW-1:0]    rdBin_reg;
    logic [PW-1:0]    rdBin_next;
    logic [PW-1:0]    rdGray_reg;
    logic [PW-1:0]    rdMeta_reg;
    logic [PW-1:0]    rdSync_reg;
    logic [PW-1:0]    wrMeta_reg;
    logic [PW-1:0]    wrSync_reg;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // Full when the writer leads the synchronised reader by the depth
    always_comb
    begin
        wrReady    = (wrBin_reg - gray2bin(rdSync_reg)) != PW'(DEPTH);
        push       = wrValid && wrReady;
        wrBin_next = wrBin_reg + PW'(push);
        rdValid    = rdGray_reg != wrSync_reg;
        pop        = rdValid && rdReady;
        rdBin_next = rdBin_reg + PW'(pop);
        rdData     = store[rdBin_reg[AW-1:0]];
    end

    always_ff @(posedge wrClk or negedge wrRstn)
    begin
        if (!wrRstn)
        begin
            wrBin_reg  <= '0;
            wrGray_reg <= '0;
            rdMeta_reg <= '0;
            rdSync_reg <= '0;
        end
        else
        begin
            wrBin_reg  <= wrBin_next;
            wrGray_reg <= wrBin_next ^ (wrBin_next >> 1);
            rdMeta_reg <= rdGray_reg;
            rdSync_reg <= rdMeta_reg;
        end
    end

    always_ff @(posedge wrClk)
    begin
        if (push)
        begin
            store[wrBin_reg[AW-1:0]] <= wrData;
        end
    end

    always_ff @(posedge rdClk or negedge rdRstn)
    begin
        if (!rdRstn)
        begin
            rdBin_reg  <= '0;
            rdGray_reg <= '0;
            wrMeta_reg <= '0;
            wrSync_reg <= '0;
        end
        else
        begin
            rdBin_reg  <= rdBin_next;
            rdGray_reg <= rdBin_next ^ (rdBin_next >> 1);
            wrMeta_reg <= wrGray_reg;
            wrSync_reg <= wrMeta_reg;
        end
    end

endmodule

`default_nettype wire

// ===== logic/ddr_burst2_sram_port.sv
// Link side, write buffer and array of the double-data-rate burst-of-two SRAM
//
// Summary of operation
// - One address bus, read and write slots alternate
// - Each address holds a two-word burst
// - Words move on both input clock rising edges
// - Separate read and write data pins
// - All inputs captured on input clock edges
// - Read outputs launched from input clock registers
// - Array writes done by self-timed sequencer
// - Mode pin high gives 2.5 cycle latency
// - Mode pin low gives one cycle latency
// - Read-valid flag marks valid output data
// - Echo clocks follow the read data
// - Reads see the newest written data
// - Only rising clock edges act
`include "ddr_burst2_sram_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module ddr_burst2_sram_port (
    // System clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rstn,
    // Link input clock pair
    input  wire logic                        kClk,
    input  wire logic                        kClkN,
    // Address and port selects
    input  wire ddr_burst2_sram_pkg::addr_t  addrIn,
    input  wire logic                        readSelN,
    input  wire logic                        writeSelN,
    // Write data
    input  wire ddr_burst2_sram_pkg::word_t  writeData,
    // Read data
    output ddr_burst2_sram_pkg::word_t       readData,
    output logic                             readValidFlag,
    // Echo clocks
    output logic                             echoTimingOut,
    output logic                             echoTimingOutN,
    // Latency strap
    input  wire logic                        latencyModePin
);
    import ddr_burst2_sram_pkg::*;

    word_t        memWord0 [0:(1<<`ADDR_W)-1];
    word_t        memWord1 [0:(1<<`ADDR_W)-1];

    logic         kRstnMeta_reg;
    logic         kRstn_reg;
    logic         modeMeta_reg;
    logic         slowMode_reg;

    logic         phase_reg;
    logic         phase_next;
    logic         rdTake_reg;
    logic         rdTake_next;
    addr_t        rdAddr_reg;
    addr_t        rdAddr_next;
    logic         wrPend_reg;
    logic         wrPend_next;
    addr_t        wrAddr_reg;
    addr_t        wrAddr_next;
    word_t        wrWord0_reg;
    word_t        wrWord0_next;
    word_t        wrWord1_reg;
    word_t        wrWord1_next;
    wrReq_t       newReq;
    wrReq_t       hold_reg;
    wrReq_t       hold_next;
    logic         holdValid_reg;
    logic         holdValid_next;
    wrReq_t       shadow_reg [0:`SHADOW_N-1];
    wrReq_t       shadow_next [0:`SHADOW_N-1];
    logic [`SHADOW_N-1:0] shadowValid_reg;
    logic [`SHADOW_N-1:0] shadowValid_next;
    logic [`SHADOW_N-1:0] hitVec;
    logic         fifoReady;

    rdPair_t      pairNow;
    rdPair_t      s1_reg;
    rdPair_t      s1_next;
    logic         s1Valid_reg;
    logic         s1Valid_next;
    rdPair_t      s2_reg;
    rdPair_t      s2_next;
    logic         s2Valid_reg;
    logic         s2Valid_next;
    word_t        qRise_reg;
    word_t        qRise_next;
    logic         validRise_reg;
    logic         validRise_next;
    word_t        qFall_reg;
    word_t        qFall_next;
    logic         validFall_reg;
    logic         validFall_next;

    commitState_t state_reg;
    commitState_t state_next;
    logic         fifoValid;
    logic         fifoPop;
    wrReq_t       fifoData;

    // Reset for the link domain: asserted at once, released on a link edge
    always_ff @(posedge kClk or negedge rstn)
    begin
        if (!rstn)
        begin
            kRstnMeta_reg <= 1'b0;
            kRstn_reg     <= 1'b0;
            modeMeta_reg  <= `MODE_RST;
            slowMode_reg  <= `MODE_RST;
        end
        else
        begin
            kRstnMeta_reg <= 1'b1;
            kRstn_reg     <= kRstnMeta_reg;
            modeMeta_reg  <= latencyModePin;
            slowMode_reg  <= modeMeta_reg;
        end
    end

    // Address slots alternate; selects and data sampled on rising edges only
    always_comb
    begin
        phase_next   = !phase_reg;
        rdTake_next  = !phase_reg && !readSelN;
        rdAddr_next  = rdTake_next ? addrIn : rdAddr_reg;
        wrPend_next  = phase_reg && !writeSelN;
        wrAddr_next  = wrPend_next ? addrIn : wrAddr_reg;
        wrWord0_next = wrPend_next ? writeData : wrWord0_reg;
        newReq       = '{addr: wrAddr_reg, word0: wrWord0_reg, word1: wrWord1_reg};
        // Hold keeps a burst until the buffer takes it
        hold_next      = hold_reg;
        holdValid_next = holdValid_reg && !fifoReady;
        if (wrPend_reg && !holdValid_next)
        begin
            hold_next      = newReq;
            holdValid_next = 1'b1;
        end
        // Newest write enters the history at index zero
        shadowValid_next = shadowValid_reg;
        for (int i = 0; i < `SHADOW_N; i++)
        begin
            shadow_next[i] = shadow_reg[i];
        end
        if (wrPend_reg)
        begin
            shadow_next[0]   = newReq;
            shadowValid_next = {shadowValid_reg[`SHADOW_N-2:0], 1'b1};
            for (int i = 1; i < `SHADOW_N; i++)
            begin
                shadow_next[i] = shadow_reg[i-1];
            end
        end
    end

    always_ff @(posedge kClk or negedge kRstn_reg)
    begin
        if (!kRstn_reg)
        begin
            phase_reg       <= `PHASE_RST;
            rdTake_reg      <= 1'b0;
            rdAddr_reg      <= '0;
            wrPend_reg      <= 1'b0;
            wrAddr_reg      <= '0;
            wrWord0_reg     <= '0;
            hold_reg        <= '0;
            holdValid_reg   <= 1'b0;
            shadowValid_reg <= '0;
            for (int i = 0; i < `SHADOW_N; i++)
            begin
                shadow_reg[i] <= '0;
            end
        end
        else
        begin
            phase_reg       <= phase_next;
            rdTake_reg      <= rdTake_next;
            rdAddr_reg      <= rdAddr_next;
            wrPend_reg      <= wrPend_next;
            wrAddr_reg      <= wrAddr_next;
            wrWord0_reg     <= wrWord0_next;
            hold_reg        <= hold_next;
            holdValid_reg   <= holdValid_next;
            shadowValid_reg <= shadowValid_next;
            for (int i = 0; i < `SHADOW_N; i++)
            begin
                shadow_reg[i] <= shadow_next[i];
            end
        end
    end

    // Address match against each recent write
    genvar g;
    generate
        for (g = 0; g < `SHADOW_N; g++)
        begin : gHit
            assign hitVec[g] = shadowValid_reg[g] && (shadow_reg[g].addr == rdAddr_reg);
        end
    endgenerate

    // Read pipe: the newest matching write overrides the array
    always_comb
    begin
        pairNow = '{word0: memWord0[rdAddr_reg], word1: memWord1[rdAddr_reg]};
        for (int i = `SHADOW_N - 1; i >= 0; i--)
        begin
            if (hitVec[i])
            begin
                pairNow = '{word0: shadow_reg[i].word0, word1: shadow_reg[i].word1};
            end
        end
        s1_next        = rdTake_reg ? pairNow : s1_reg;
        s1Valid_next   = rdTake_reg;
        s2_next        = s1Valid_reg ? s1_reg : s2_reg;
        s2Valid_next   = s1Valid_reg;
        validRise_next = slowMode_reg ? s2Valid_reg : rdTake_reg;
        qRise_next     = qRise_reg;
        if (!slowMode_reg && rdTake_reg)
        begin
            qRise_next = pairNow.word0;
        end
        else if (slowMode_reg && s2Valid_reg)
        begin
            qRise_next = s2_reg.word1;
        end
    end

    always_ff @(posedge kClk or negedge kRstn_reg)
    begin
        if (!kRstn_reg)
        begin
            s1_reg        <= '0;
            s1Valid_reg   <= 1'b0;
            s2_reg        <= '0;
            s2Valid_reg   <= 1'b0;
            qRise_reg     <= '0;
            validRise_reg <= 1'b0;
        end
        else
        begin
            s1_reg        <= s1_next;
            s1Valid_reg   <= s1Valid_next;
            s2_reg        <= s2_next;
            s2Valid_reg   <= s2Valid_next;
            qRise_reg     <= qRise_next;
            validRise_reg <= validRise_next;
        end
    end

    // Complement clock edge: second write word and the half-cycle read slot
    always_comb
    begin
        wrWord1_next   = wrPend_reg ? writeData : wrWord1_reg;
        validFall_next = slowMode_reg ? s2Valid_reg : s1Valid_reg;
        qFall_next     = qFall_reg;
        if (!slowMode_reg && s1Valid_reg)
        begin
            qFall_next = s1_reg.word1;
        end
        else if (slowMode_reg && s2Valid_reg)
        begin
            qFall_next = s2_reg.word0;
        end
    end

    always_ff @(posedge kClkN or negedge kRstn_reg)
    begin
        if (!kRstn_reg)
        begin
            wrWord1_reg   <= '0;
            qFall_reg     <= '0;
            validFall_reg <= 1'b0;
        end
        else
        begin
            wrWord1_reg   <= wrWord1_next;
            qFall_reg     <= qFall_next;
            validFall_reg <= validFall_next;
        end
    end

    // Clock level picks the register of the last rising edge
    assign readData       = kClk ? qRise_reg : qFall_reg;
    assign readValidFlag  = kClk ? validRise_reg : validFall_reg;
    assign echoTimingOut  = kClk;
    assign echoTimingOutN = kClkN;

    async_pair_fifo #(
        .WIDTH ($bits(wrReq_t)),
        .DEPTH (`WBUF_DEPTH)
    ) wrBuf (
        .wrClk   (kClk),
        .wrRstn  (kRstn_reg),
        .wrValid (holdValid_reg),
        .wrReady (fifoReady),
        .wrData  (hold_reg),
        .rdClk   (mclk),
        .rdRstn  (rstn),
        .rdValid (fifoValid),
        .rdReady (fifoPop),
        .rdData  (fifoData)
    );

    // Self-timed commit: one word per system cycle, pop in the cycle of the second
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            CM_IDLE:  state_next = fifoValid ? CM_WORD0 : CM_IDLE;
            CM_WORD0: state_next = CM_WORD1;
            CM_WORD1: state_next = CM_IDLE;
            default:  state_next = CM_IDLE;
        endcase
        fifoPop = (state_reg == CM_WORD1);
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= CM_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (state_reg == CM_WORD0)
        begin
            memWord0[fifoData.addr] <= fifoData.word0;
        end
        if (state_reg == CM_WORD1)
        begin
            memWord1[fifoData.addr] <= fifoData.word1;
        end
    end

    phase_toggle_a: assert property (@(posedge kClk) disable iff (!kRstn_reg)
        1'b1 |=> phase_reg != $past(phase_reg))
        else $error("address slot did not alternate");
    slot_order_a: assert property (@(posedge kClk) disable iff (!kRstn_reg)
        (rdTake_reg |-> phase_reg) and (wrPend_reg |-> !phase_reg))
        else $error("read or write sampled in the wrong slot");
    fast_latency_a: assert property (@(posedge kClk) disable iff (!kRstn_reg)
        rdTake_reg && !slowMode_reg |=> validRise_reg && qRise_reg == $past(pairNow.word0))
        else $error("one cycle read data missing");
    slow_latency_a: assert property (@(posedge kClk) disable iff (!kRstn_reg)
        rdTake_reg && slowMode_reg && $stable(slowMode_reg) |-> ##3 validRise_reg)
        else $error("slow read second word missing");
    idle_port_a: assert property (@(posedge kClk) disable iff (!kRstn_reg)
        !rdTake_reg && !slowMode_reg |=> !validRise_reg)
        else $error("read valid without a read");
    fall_word_a: assert property (@(posedge kClkN) disable iff (!kRstn_reg)
        s1Valid_reg && !slowMode_reg |=> validFall_reg && qFall_reg == $past(s1_reg.word1))
        else $error("second read word not on complement edge");
    newest_write_a: assert property (@(posedge kClk) disable iff (!kRstn_reg)
        wrPend_reg |=> shadowValid_reg[0] && shadow_reg[0].addr == $past(wrAddr_reg))
        else $error("write missing from recent history");
    hold_stall_a: assert property (@(posedge kClk) disable iff (!kRstn_reg)
        holdValid_reg && !fifoReady |=> holdValid_reg && $stable(hold_reg))
        else $error("held write lost under back-pressure");
    commit_seq_a: assert property (@(posedge mclk) disable iff (!rstn)
        state_reg == CM_WORD0 |=> state_reg == CM_WORD1 ##1 state_reg == CM_IDLE)
        else $error("array write sequence broken");

endmodule

`default_nettype wire

// ===== verification/link_ctrl_model.sv
// Memory controller model that drives the link side of the SRAM port
`timescale 1ns/10ps
`default_nettype none

module link_ctrl_model (
    // Link clock and reset
    input  wire logic                  kClk,
    input  wire logic                  rstn,
    // Requests towards the port
    output ddr_burst2_sram_pkg::addr_t addrIn,
    output logic                       readSelN,
    output logic                       writeSelN,
    output ddr_burst2_sram_pkg::word_t writeData
);
    import ddr_burst2_sram_pkg::*;

    addr_t  rdQ[$];
    wrReq_t wrQ[$];
    wrReq_t cur;
    int     rises = 0;
    logic   wrNow = 1'b0;

    initial
    begin
        addrIn = 8'h00;
        readSelN = 1'b1;
        writeSelN = 1'b1;
        writeData = 36'h0;
    end

    // Counts link rises since reset so that read and write slots can be told apart
    always @(posedge kClk or negedge rstn)
    begin
        if (!rstn)
            rises <= 0;
        else
            rises <= rises + 1;
    end

    // Next slot set up a quarter cycle before its rise; released lines show inverted values
    always @(negedge kClk)
    begin
        #3.75;
        wrNow = 1'b0;
        addrIn = ~addrIn;
        writeData = ~writeData;
        readSelN = 1'b1;
        writeSelN = 1'b1;
        if (rstn && rises >= 2 && rises % 2 == 0)
        begin
            writeSelN = 1'($urandom);
            if (rdQ.size() > 0)
            begin
                readSelN = 1'b0;
                addrIn = rdQ.pop_front();
            end
        end
        else if (rstn && rises >= 3)
        begin
            readSelN = 1'($urandom);
            if (wrQ.size() > 0)
            begin
                cur = wrQ.pop_front();
                writeSelN = 1'b0;
                addrIn = cur.addr;
                writeData = cur.word0;
                wrNow = 1'b1;
            end
        end
    end

    // Second word of a burst is held around the complement clock rise
    always @(posedge kClk)
    begin
        #3.75;
        if (wrNow)
            writeData = cur.word1;
        else
            writeData = ~writeData;
    end
endmodule
`default_nettype wire

// ===== verification/ddr_burst2_sram_port_tb.sv
// Self-checking testbench of the double-data-rate burst-of-two SRAM port
`timescale 1ns/10ps
`default_nettype none

module ddr_burst2_sram_port_tb;
    import ddr_burst2_sram_pkg::*;

    typedef struct {
        int    h;
        word_t w;
    } exp_t;

    // Long enough for four link clock periods
    localparam int RST_CYC = 14;

    logic    mclk = 1'b0;
    logic    kClk = 1'b0;
    logic    kClkN;
    logic    rstn = 1'b0;
    logic    latencyModePin = 1'b0;
    addr_t   addrIn;
    logic    readSelN;
    logic    writeSelN;
    word_t   writeData;
    word_t   readData;
    logic    readValidFlag;
    logic    echoTimingOut;
    logic    echoTimingOutN;
    int      n_fail = 0;
    int      n_checks = 0;
    int      halfIdx = 0;
    exp_t    expQ[$];
    rdPair_t refMem[addr_t];

    assign kClkN = ~kClk;

    initial
        forever #2.5 mclk = ~mclk;

    initial
    begin
        #3.3;
        forever #7.5 kClk = ~kClk;
    end

    ddr_burst2_sram_port ddr_burst2_sram_port_i (
        .mclk(mclk), .rstn(rstn), .kClk(kClk), .kClkN(kClkN), .addrIn(addrIn),
        .readSelN(readSelN), .writeSelN(writeSelN), .writeData(writeData), .readData(readData),
        .readValidFlag(readValidFlag), .echoTimingOut(echoTimingOut),
        .echoTimingOutN(echoTimingOutN), .latencyModePin(latencyModePin)
    );

    link_ctrl_model link_ctrl_model_i (
        .kClk(kClk), .rstn(rstn), .addrIn(addrIn), .readSelN(readSelN),
        .writeSelN(writeSelN), .writeData(writeData)
    );

    task automatic check(input string what, input word_t exp, input word_t got);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Half cycles from the read rise to the first word
    function automatic int lat_halves(input logic mode);
        return mode ? 5 : 2;
    endfunction

    always @(kClk)
        halfIdx++;

    // Reference memory follows the requests in slot order and predicts every read word
    always @(posedge kClk)
    begin
        exp_t  e;
        addr_t wA;
        word_t w0;
        #1;
        if (rstn && link_ctrl_model_i.rises % 2 == 1 && readSelN === 1'b0)
        begin
            e.h = halfIdx + lat_halves(latencyModePin);
            e.w = refMem[addrIn].word0;
            expQ.push_back(e);
            e.h++;
            e.w = refMem[addrIn].word1;
            expQ.push_back(e);
        end
        if (rstn && link_ctrl_model_i.rises % 2 == 0 && writeSelN === 1'b0)
        begin
            wA = addrIn;
            w0 = writeData;
            @(negedge kClk);
            #1;
            refMem[wA] = '{w0, writeData};
        end
    end

    // Output monitor, once in every half cycle
    always @(kClk)
    begin
        exp_t e;
        #2;
        check("echo clocks", word_t'({kClk, kClkN}), word_t'({echoTimingOut, echoTimingOutN}));
        if (expQ.size() > 0 && expQ[0].h == halfIdx)
        begin
            e = expQ.pop_front();
            check("read valid flag", 36'h1, word_t'(readValidFlag));
            check("read data", e.w, readData);
        end
        else
            check("read valid flag", 36'h0, word_t'(readValidFlag));
    end

    task automatic push_wr(input addr_t a);
        wrReq_t r;
        r.addr = a;
        r.word0 = word_t'({$urandom, $urandom});
        r.word1 = word_t'({$urandom, $urandom});
        link_ctrl_model_i.wrQ.push_back(r);
    endtask

    task automatic drain();
        for (int i = 0; i < 3000 && link_ctrl_model_i.rdQ.size() + link_ctrl_model_i.wrQ.size()
             + expQ.size() > 0; i++)
            @(negedge mclk);
        repeat (10) @(negedge mclk);
    endtask

    task automatic run_test(input logic mode);
        addr_t a;
        @(negedge mclk);
        rstn = 1'b0;
        latencyModePin = mode;
        repeat (RST_CYC) @(negedge mclk);
        expQ.delete();
        rstn = 1'b1;
        for (int i = 0; i < 8; i++)
            push_wr(addr_t'(i));
        push_wr(8'hFF);
        drain();
        // Read and write of the top address in the same slot pair
        push_wr(8'hFF);
        link_ctrl_model_i.rdQ.push_back(8'hFF);
        link_ctrl_model_i.rdQ.push_back(8'hFF);
        link_ctrl_model_i.rdQ.push_back(8'h00);
        repeat (200)
        begin
            a = addr_t'($urandom_range(7));
            if ($urandom_range(1))
                push_wr(a);
            if ($urandom_range(1))
                link_ctrl_model_i.rdQ.push_back(a);
            if ($urandom_range(3) == 0)
                repeat (20) @(negedge mclk);
        end
        drain();
        check("pending reads", 36'h0, word_t'(expQ.size()));
        $display("test with latency mode %0b done", mode);
    endtask

    initial
    begin
        void'($urandom(32'hE3A4));
        run_test(1'b0);
        run_test(1'b1);
        give_verdict();
    end

    initial
    begin
        #200us;
        n_fail++;
        give_verdict();
    end
endmodule
`default_nettype wire
